// >>> selftest_pkg.sv
/*
  Constants for the startup self-test and fault report logic.
  Assumes a single 20 MHz clock domain.
*/
package selftest_pkg;
  localparam int          CLK_HZ          = 20_000_000;
  localparam int          NUM_RAILS       = 5;
  // rail index within the detector vectors
  localparam int          RAIL_PREREG     = 0;
  localparam int          RAIL_MCU        = 1;
  localparam int          RAIL_GEN5V      = 2;
  localparam int          RAIL_SENS1      = 3;
  localparam int          RAIL_SENS2      = 4;
  // cycles each detector stimulus is held, and settle time per step
  localparam logic [7:0]  STIM_CYCLES     = 8'h10;
  localparam logic [7:0]  SETTLE_CYCLES   = 8'h04;
  // reset values
  localparam logic [4:0]  VERIFY_RST      = 5'h00;
  localparam logic        SENS_EN_RST     = 1'b0;
  localparam logic        MCU_SEL_5V      = 1'b1;
endpackage : selftest_pkg

// >>> stim_if.sv
/*
  Interface carrying detector status, test phases, clear and verify results between
  the sequencer and the verify latch.
  Assumes both ends share i_clk.
*/
`timescale 1ns/10ps
interface stim_if;
  logic [4:0] uv_diag;
  logic [4:0] ov_diag;
  logic       ot_diag;
  logic       clear;
  logic       uv_phase;
  logic       ov_phase;
  logic       ot_phase;
  logic [4:0] uv_ok;
  logic [4:0] ov_ok;
  logic       ot_ok;
  modport seq   (output uv_diag, ov_diag, ot_diag, clear, uv_phase,
                 ov_phase, ot_phase, input uv_ok, ov_ok, ot_ok);
  modport latch (input uv_diag, ov_diag, ot_diag, clear, uv_phase,
                 ov_phase, ot_phase, output uv_ok, ov_ok, ot_ok);
endinterface : stim_if

// >>> verify_latch.sv
/*
  Verify result latches: a uv or ov bit sets when its detector toggles,
  the ot bit when its detector rises, during its own test phase, and holds until the next clear.
  Assumes synchronised diagnostic inputs.
*/
`timescale 1ns/10ps
module verify_latch
  import selftest_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_nrst,
  stim_if.latch     s
);
  logic [4:0] uv_prev_q;
  logic [4:0] ov_prev_q;
  logic       ot_prev_q;
  logic [4:0] uv_ok_q;
  logic [4:0] ov_ok_q;
  logic       ot_ok_q;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      uv_prev_q <= VERIFY_RST;
      ov_prev_q <= VERIFY_RST;
      ot_prev_q <= 1'b0;
    end else begin
      uv_prev_q <= s.uv_diag;
      ov_prev_q <= s.ov_diag;
      ot_prev_q <= s.ot_diag;
    end
  end

  // ------------------------------------------------------------
  // per-rail latches
  // ------------------------------------------------------------
  for (genvar g = 0; g < NUM_RAILS; g++) begin : g_rail
    always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
        uv_ok_q[g] <= 1'b0;
        ov_ok_q[g] <= 1'b0;
      end else begin
        if (s.uv_phase && (s.uv_diag[g] != uv_prev_q[g]))
          uv_ok_q[g] <= 1'b1;
        else if (s.clear)
          uv_ok_q[g] <= 1'b0;
        if (s.ov_phase && (s.ov_diag[g] != ov_prev_q[g]))
          ov_ok_q[g] <= 1'b1;
        else if (s.clear)
          ov_ok_q[g] <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ot_ok_q <= 1'b0;
    end else if (s.ot_phase && s.ot_diag && !ot_prev_q) begin
      ot_ok_q <= 1'b1;
    end else if (s.clear) begin
      ot_ok_q <= 1'b0;
    end
  end

  assign s.uv_ok = uv_ok_q;
  assign s.ov_ok = ov_ok_q;
  assign s.ot_ok = ot_ok_q;
endmodule : verify_latch

// >>> startup_self_test_fault_report.sv
/*
  Startup self-test sequencer, enable logic, supply-good and fault
  flag outputs, power-on-enable monitor.
  Assumes analog comparator outputs and pins arrive asynchronously
  and the verify bits are read out by a separate serial block.
*/
`timescale 1ns/10ps

module startup_self_test_fault_report
  import selftest_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_logic_enable_in,
  input  wire logic       i_ignition_enable_in,
  input  wire logic [4:0] i_uv_diag,
  input  wire logic [4:0] i_ov_diag,
  input  wire logic       i_ot_diag,
  input  wire logic       i_other_fault,
  input  wire logic       i_power_on_enable_pin,
  input  wire logic       i_power_on_enable_demand,
  input  wire logic       i_mcu_rail_voltage_select,
  input  wire logic       i_sensor_rail_enable,
  input  wire logic       i_verify_reset,
  output logic            o_regulators_enable,
  output logic            o_supply_good_reset_out,
  output logic            o_fault_flag_low,
  output logic            o_power_on_enable_out,
  output logic            o_output_enable_match_status,
  output logic            o_mcu_rail_5v,
  output logic            o_sensor_rails_enable,
  output logic [4:0]      o_uv_stim,
  output logic [4:0]      o_ov_stim,
  output logic            o_ot_stim,
  output logic [4:0]      o_uv_verify,
  output logic [4:0]      o_ov_verify,
  output logic            o_overtemp_verify_bit,
  output logic            o_selftest_done,
  output logic            o_selftest_fail
);
  typedef enum logic [2:0] {
    ST_CLEAR, ST_UV, ST_OV, ST_OT, ST_DONE
  } seq_e;

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  localparam int SW = 17;
  localparam logic [SW-1:0] SYNC_RST = {{(SW-2){1'b0}}, MCU_SEL_5V,
                                        SENS_EN_RST};
  logic [SW-1:0] in_raw;
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  assign in_raw = {i_logic_enable_in, i_ignition_enable_in, i_uv_diag,
                   i_ov_diag, i_ot_diag, i_other_fault,
                   i_power_on_enable_pin, i_mcu_rail_voltage_select,
                   i_sensor_rail_enable};

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sync1_q <= SYNC_RST;
      sync2_q <= SYNC_RST;
    end else begin
      sync1_q <= in_raw;
      sync2_q <= sync1_q;
    end
  end

  logic       en_logic, en_ign, ot_s, other_s, poe_pin_s, sel_s, sens_s;
  logic [4:0] uv_s, ov_s;
  assign {en_logic, en_ign, uv_s, ov_s, ot_s, other_s, poe_pin_s,
          sel_s, sens_s} = sync2_q;

  // ------------------------------------------------------------
  // self-test sequencer
  // ------------------------------------------------------------
  seq_e       state_q;
  logic [2:0] rail_q;
  logic [7:0] cnt_q;
  logic       step_end;
  assign step_end = (cnt_q == STIM_CYCLES + SETTLE_CYCLES);

  stim_if s ();
  verify_latch u_verify (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .s      (s)
  );

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= ST_CLEAR;
      rail_q  <= 3'h0;
      cnt_q   <= 8'h00;
    end else begin
      unique case (state_q)
        ST_CLEAR: begin
          state_q <= ST_UV;
          rail_q  <= 3'h0;
          cnt_q   <= 8'h00;
        end
        ST_UV, ST_OV: begin
          if (!step_end) begin
            cnt_q <= cnt_q + 8'h01;
          end else begin
            cnt_q <= 8'h00;
            if (rail_q == 3'(NUM_RAILS - 1)) begin
              rail_q  <= 3'h0;
              state_q <= (state_q == ST_UV) ? ST_OV : ST_OT;
            end else begin
              rail_q <= rail_q + 3'h1;
            end
          end
        end
        ST_OT: begin
          if (!step_end) begin
            cnt_q <= cnt_q + 8'h01;
          end else begin
            cnt_q   <= 8'h00;
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          if (i_verify_reset) begin
            state_q <= ST_CLEAR;
          end
        end
      endcase
    end
  end

  logic stim_on;
  assign stim_on = (cnt_q < STIM_CYCLES);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_uv_stim <= 5'h00;
    end else begin
      o_uv_stim <= (state_q == ST_UV && stim_on) ?
                   5'(5'h01 << rail_q) : 5'h00;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ov_stim <= 5'h00;
    end else begin
      o_ov_stim <= (state_q == ST_OV && stim_on) ?
                   5'(5'h01 << rail_q) : 5'h00;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ot_stim <= 1'b0;
    end else begin
      o_ot_stim <= (state_q == ST_OT) && stim_on;
    end
  end

  assign s.uv_diag  = uv_s;
  assign s.ov_diag  = ov_s;
  assign s.ot_diag  = ot_s;
  assign s.clear    = (state_q == ST_CLEAR);
  assign s.uv_phase = (state_q == ST_UV);
  assign s.ov_phase = (state_q == ST_OV);
  assign s.ot_phase = (state_q == ST_OT);

  // ------------------------------------------------------------
  // regulator enable and rail controls
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_regulators_enable <= 1'b0;
    end else begin
      o_regulators_enable <= en_logic | en_ign;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_mcu_rail_5v <= MCU_SEL_5V;
    end else begin
      o_mcu_rail_5v <= sel_s;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sensor_rails_enable <= SENS_EN_RST;
    end else begin
      o_sensor_rails_enable <= sens_s;
    end
  end

  // ------------------------------------------------------------
  // supply good
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_supply_good_reset_out <= 1'b0;
    end else begin
      o_supply_good_reset_out <= !uv_s[RAIL_MCU] && !ov_s[RAIL_MCU] &&
                                 (state_q == ST_DONE);
    end
  end

  // ------------------------------------------------------------
  // power-on-enable monitor
  // ------------------------------------------------------------
  logic poe_mismatch;
  assign poe_mismatch = (poe_pin_s != o_power_on_enable_out);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_power_on_enable_out <= 1'b0;
    end else begin
      o_power_on_enable_out <= i_power_on_enable_demand;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_output_enable_match_status <= 1'b1;
    end else begin
      o_output_enable_match_status <= !poe_mismatch;
    end
  end

  // ------------------------------------------------------------
  // fault flag
  // ------------------------------------------------------------
  logic [NUM_RAILS-1:0] rail_fault;
  logic                 other_rail_fault;
  logic                 selftest_fail_d;

  // mcu rail status goes to supply good only
  for (genvar g = 0; g < NUM_RAILS; g++) begin : g_rail_fault
    if (g == RAIL_MCU) begin : g_mcu
      assign rail_fault[g] = 1'b0;
    end else begin : g_other
      assign rail_fault[g] = uv_s[g] || ov_s[g];
    end
  end
  assign other_rail_fault = (state_q == ST_DONE) && (|rail_fault);
  assign selftest_fail_d  = (state_q == ST_DONE) &&
                            ((s.uv_ok != 5'h1F) ||
                             (s.ov_ok != 5'h1F) ||
                             !s.ot_ok);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_fault_flag_low <= 1'b1;
    end else begin
      o_fault_flag_low <= !((state_q == ST_OT) ||
                            poe_mismatch ||
                            other_s ||
                            other_rail_fault ||
                            selftest_fail_d);
    end
  end

  // ------------------------------------------------------------
  // readable results
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_uv_verify           <= VERIFY_RST;
      o_ov_verify           <= VERIFY_RST;
      o_overtemp_verify_bit <= 1'b0;
    end else begin
      o_uv_verify           <= s.uv_ok;
      o_ov_verify           <= s.ov_ok;
      o_overtemp_verify_bit <= s.ot_ok;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_selftest_done <= 1'b0;
    end else begin
      o_selftest_done <= (state_q == ST_DONE);
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_selftest_fail <= 1'b0;
    end else begin
      o_selftest_fail <= selftest_fail_d;
    end
  end
endmodule : startup_self_test_fault_report

// >>> selftest_props.sv
/*
  Concurrent checks on the self-test top module ports.
  Assumes one clock i_clk and async active-low i_nrst.
*/
`timescale 1ns/10ps
// ------------------------------------------------------------------
// checker
// ------------------------------------------------------------------
module selftest_props
  import selftest_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_nrst,
  input wire logic       i_logic_enable_in,
  input wire logic       i_ignition_enable_in,
  input wire logic [4:0] i_uv_diag,
  input wire logic       i_other_fault,
  input wire logic       i_power_on_enable_pin,
  input wire logic       i_power_on_enable_demand,
  input wire logic       i_mcu_rail_voltage_select,
  input wire logic       i_sensor_rail_enable,
  input wire logic       i_verify_reset,
  input wire logic       o_regulators_enable,
  input wire logic       o_supply_good_reset_out,
  input wire logic       o_fault_flag_low,
  input wire logic       o_output_enable_match_status,
  input wire logic       o_mcu_rail_5v,
  input wire logic       o_sensor_rails_enable,
  input wire logic [4:0] o_uv_stim,
  input wire logic       o_ot_stim,
  input wire logic [4:0] o_uv_verify,
  input wire logic [4:0] o_ov_verify,
  input wire logic       o_overtemp_verify_bit,
  input wire logic       o_selftest_done,
  input wire logic       o_selftest_fail
);
  logic [10:0] vb;
  logic        pe;
  assign vb = {o_uv_verify, o_ov_verify, o_overtemp_verify_bit};
  assign pe = i_power_on_enable_pin == i_power_on_enable_demand;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_stim_start; $rose(o_uv_stim[0]); endsequence
  sequence s_ot_run; o_ot_stim ##1 o_ot_stim; endsequence
  a_enable_on: assert property ((i_logic_enable_in | i_ignition_enable_in)[*4]
    |-> o_regulators_enable) else $error("regulators off");
  a_enable_off: assert property ((!(i_logic_enable_in | i_ignition_enable_in))
    [*4] |-> !o_regulators_enable) else $error("regulators on");
  a_supply_mcu: assert property (i_uv_diag[RAIL_MCU][*4]
    |-> !o_supply_good_reset_out) else $error("supply good high");
  a_other_fault: assert property (i_other_fault[*4] |-> !o_fault_flag_low)
    else $error("fault flag high");
  a_poe_bad: assert property ((!pe && $stable(pe))[*4]
    |-> !o_output_enable_match_status && !o_fault_flag_low)
    else $error("mismatch unseen");
  a_poe_good: assert property ((pe && $stable(pe))[*4]
    |-> o_output_enable_match_status) else $error("match low");
  a_verify_sticky: assert property (!$past(i_verify_reset)
    && !$past(i_verify_reset, 2) && !$past(i_verify_reset, 3)
    |-> (vb & $past(vb)) == $past(vb)) else $error("verify lost");
  a_clear_first: assert property (s_stim_start |-> vb == 11'h000)
    else $error("verify not cleared");
  a_ot_flag: assert property (s_ot_run |-> !o_fault_flag_low)
    else $error("flag high in ot test");
  a_verdict_bits: assert property (o_selftest_done && $past(o_selftest_done)
    |-> o_selftest_fail == !(&vb)) else $error("verdict wrong");
  a_fail_flag: assert property (o_selftest_fail && $past(o_selftest_fail)
    |-> !o_fault_flag_low) else $error("fail not flagged");
  a_mcu_select: assert property ($stable(i_mcu_rail_voltage_select)[*4]
    |-> o_mcu_rail_5v == i_mcu_rail_voltage_select)
    else $error("select wrong");
  a_sensor_off: assert property ((!i_sensor_rail_enable)[*4]
    |-> !o_sensor_rails_enable) else $error("sensor on");
  a_stim_hold: assert property ($rose(|o_uv_stim) |-> (|o_uv_stim)[*8])
    else $error("stim short");
endmodule : selftest_props

bind startup_self_test_fault_report selftest_props PROPS (.*);

// >>> rail_detector_model.sv
/*
  Comparator model: each detector not masked dead follows its stimulus one cycle later; mcu_low also sets uv bit 1.
  Assumes dead masks and mcu_low are set by the bench.
*/
`timescale 1ns/10ps
// ------------------------------------------------------------------
// detectors
// ------------------------------------------------------------------
module rail_detector_model
(
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  input  wire logic [4:0] i_uv_stim,
  input  wire logic [4:0] i_ov_stim,
  input  wire logic       i_ot_stim,
  input  wire logic [4:0] i_uv_dead,
  input  wire logic [4:0] i_ov_dead,
  input  wire logic       i_ot_dead,
  input  wire logic       i_mcu_low,
  output logic      [4:0] o_uv_diag,
  output logic      [4:0] o_ov_diag,
  output logic            o_ot_diag
);
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_uv_diag <= 5'h00;
      o_ov_diag <= 5'h00;
      o_ot_diag <= 1'b0;
    end else begin
      o_uv_diag <= (i_uv_stim & ~i_uv_dead) | {3'h0, i_mcu_low, 1'b0};
      o_ov_diag <= i_ov_stim & ~i_ov_dead;
      o_ot_diag <= i_ot_stim & ~i_ot_dead;
    end
  end
endmodule : rail_detector_model

// >>> startup_self_test_fault_report_tb_top.sv
/*
  Testbench for the self-test and fault report block.
  Assumes the detector model answers the stimulus outputs.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e); end end
// ------------------------------------------------------------------
// bench
// ------------------------------------------------------------------
module startup_self_test_fault_report_tb_top
  import selftest_pkg::*;
;
  int         fails = 0, checked = 0, cycles = 0;
  int         uv_on = 0, ov_on = 0, ot_on = 0, runs = 0;
  logic       i_clk, i_nrst, i_logic_enable_in, i_ignition_enable_in;
  logic       i_other_fault, i_power_on_enable_pin, i_power_on_enable_demand;
  logic       i_mcu_rail_voltage_select, i_sensor_rail_enable, i_verify_reset;
  logic       i_ot_diag, o_ot_stim, o_overtemp_verify_bit, ot_dead, mcu_low;
  logic       o_regulators_enable, o_supply_good_reset_out, o_fault_flag_low;
  logic       o_power_on_enable_out, o_output_enable_match_status;
  logic       o_mcu_rail_5v, o_sensor_rails_enable;
  logic       o_selftest_done, o_selftest_fail;
  logic [4:0] i_uv_diag, i_ov_diag, o_uv_stim, o_ov_stim;
  logic [4:0] o_uv_verify, o_ov_verify, uv_dead, ov_dead;

  startup_self_test_fault_report DUT (.*);
  rail_detector_model MDL (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_uv_stim(o_uv_stim), .i_ov_stim(o_ov_stim), .i_ot_stim(o_ot_stim),
    .i_uv_dead(uv_dead), .i_ov_dead(ov_dead), .i_ot_dead(ot_dead),
    .i_mcu_low(mcu_low), .o_uv_diag(i_uv_diag), .o_ov_diag(i_ov_diag),
    .o_ot_diag(i_ot_diag));

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // stimulus cycles seen, one count per driven bit
  always @(negedge i_clk) begin
    uv_on += $countones(o_uv_stim);
    ov_on += $countones(o_ov_stim);
    ot_on += o_ot_stim;
  end

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 6000) begin
      fails++;
      print_verdict();
    end
  end

  task print_verdict;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  task settle;
    repeat (5) @(negedge i_clk);
  endtask : settle

  task wait_done;
    int n;
    n = 0;
    while (o_selftest_done !== 1'b1 && n < 400) begin
      @(negedge i_clk);
      n++;
    end
    `CHK(o_selftest_done, 1'b1)
    runs++;
    `CHK(uv_on, runs * NUM_RAILS * STIM_CYCLES)
    `CHK(ov_on, runs * NUM_RAILS * STIM_CYCLES)
    `CHK(ot_on, runs * STIM_CYCLES)
    settle();
  endtask : wait_done

  task rerun(input logic [4:0] ud, input logic [4:0] od, input logic td);
    uv_dead = ud;
    ov_dead = od;
    ot_dead = td;
    i_verify_reset = 1'b1;
    @(negedge i_clk);
    i_verify_reset = 1'b0;
    repeat (4) @(negedge i_clk);
    wait_done();
    `CHK(o_uv_verify, 5'h1F & ~ud)
    `CHK(o_ov_verify, 5'h1F & ~od)
    `CHK(o_overtemp_verify_bit, ~td)
    `CHK(o_selftest_fail, |{ud, od, td})
    `CHK(o_fault_flag_low, ~|{ud, od, td})
    $display("test rerun done");
  endtask : rerun

  initial begin
    {i_nrst, i_logic_enable_in, i_ignition_enable_in, i_other_fault} = 4'h0;
    {i_power_on_enable_pin, i_power_on_enable_demand} = 2'h0;
    {i_sensor_rail_enable, i_verify_reset, ot_dead, mcu_low} = 4'h0;
    i_mcu_rail_voltage_select = 1'b1;
    uv_dead = 5'h00;
    ov_dead = 5'h00;
    repeat (12) @(negedge i_clk);
    i_nrst = 1'b1;
    `CHK(o_sensor_rails_enable, 1'b0)
    wait_done();
    `CHK(o_uv_verify, 5'h1F)
    `CHK(o_ov_verify, 5'h1F)
    `CHK(o_overtemp_verify_bit, 1'b1)
    `CHK(o_fault_flag_low, 1'b1)
    `CHK(o_supply_good_reset_out, 1'b1)
    $display("test startup done");
    for (int k = 0; k < 4; k++) begin
      {i_logic_enable_in, i_ignition_enable_in} = k[1:0];
      settle();
      `CHK(o_regulators_enable, |k[1:0])
    end
    for (int k = 0; k < 2; k++) begin
      i_mcu_rail_voltage_select = k[0];
      i_sensor_rail_enable = k[0];
      settle();
      `CHK(o_mcu_rail_5v, k[0])
      `CHK(o_sensor_rails_enable, k[0])
    end
    $display("test enables done");
    i_power_on_enable_demand = 1'b1;
    settle();
    `CHK(o_power_on_enable_out, 1'b1)
    `CHK(o_output_enable_match_status, 1'b0)
    `CHK(o_fault_flag_low, 1'b0)
    i_power_on_enable_pin = 1'b1;
    settle();
    `CHK(o_output_enable_match_status, 1'b1)
    `CHK(o_fault_flag_low, 1'b1)
    $display("test poe done");
    i_other_fault = 1'b1;
    settle();
    `CHK(o_fault_flag_low, 1'b0)
    `CHK(o_supply_good_reset_out, 1'b1)
    i_other_fault = 1'b0;
    mcu_low = 1'b1;
    settle();
    `CHK(o_supply_good_reset_out, 1'b0)
    `CHK(o_fault_flag_low, 1'b1)
    mcu_low = 1'b0;
    settle();
    $display("test faults done");
    rerun(5'h08, 5'h01, 1'b1);
    rerun(5'h00, 5'h00, 1'b0);
    print_verdict();
  end
endmodule : startup_self_test_fault_report_tb_top
